/* File: dv/dpbram_assertions.sv */
// Port checker for the two-port block memory top.
// Assumes binding to dpbram_top; sees only its ports.
`timescale 1ns/1ps
module dpbram_assertions #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    // System
    input wire logic              SYS_CLK,
    input wire logic              RST,
    // Read port
    input wire logic              RD_CLK,
    input wire logic              RD_GO,
    input wire logic              RD_CLOCK_GATE,
    input wire logic [DATA_W-1:0] RD_DATA,
    // Preload and status
    input wire logic              CFG_LOAD_VALID,
    input wire logic [ADDR_W-1:0] CFG_LOAD_ADDR,
    input wire logic              CFG_DONE,
    input wire logic              USER_READY,
    input wire logic              CFG_LOAD_REFUSED
);
    logic rclk_q;
    logic rd_take;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // Same sample history as the design, so edges line up
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rclk_q <= 1'b0;
        end else begin
            rclk_q <= RD_CLK;
        end
    end
    assign rd_take = RD_CLK && !rclk_q && RD_GO && RD_CLOCK_GATE && USER_READY;
    ready_hold_a: assert property (USER_READY |=> USER_READY)
        else $error("user phase left without reset");
    ready_set_a: assert property (CFG_DONE |=> USER_READY)
        else $error("user phase not entered");
    ready_wait_a: assert property (!CFG_DONE && !USER_READY |=> !USER_READY)
        else $error("user phase entered early");
    refuse_set_a: assert property (
        CFG_LOAD_VALID && (CFG_LOAD_ADDR == 8'h00 || USER_READY) |=> CFG_LOAD_REFUSED)
        else $error("bad preload not refused");
    load_accept_a: assert property (
        CFG_LOAD_VALID && CFG_LOAD_ADDR != 8'h00 && !USER_READY |=> !CFG_LOAD_REFUSED)
        else $error("good preload refused");
    refuse_cause_a: assert property (!CFG_LOAD_VALID |=> !CFG_LOAD_REFUSED)
        else $error("refusal without a load");
    rd_hold_a: assert property ($changed(RD_DATA) |-> $past(rd_take, 2))
        else $error("read data moved without a read");
    rd_cfg_block_a: assert property (
        RD_CLK && !rclk_q && !USER_READY |-> ##2 $stable(RD_DATA))
        else $error("read served in config phase");
endmodule
bind dpbram_top dpbram_assertions #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .RD_CLK(RD_CLK), .RD_GO(RD_GO),
    .RD_CLOCK_GATE(RD_CLOCK_GATE), .RD_DATA(RD_DATA), .CFG_LOAD_VALID(CFG_LOAD_VALID),
    .CFG_LOAD_ADDR(CFG_LOAD_ADDR), .CFG_DONE(CFG_DONE), .USER_READY(USER_READY),
    .CFG_LOAD_REFUSED(CFG_LOAD_REFUSED));

/* File: dv/dpbram_fabric.sv */
// User fabric model driving both memory ports and the preload.
// Assumes one clock; port clocks are pulses made from it.
`timescale 1ns/1ps
module dpbram_fabric (
    // System
    input  wire logic   clk,
    // Write port
    output logic        wclk,
    output logic        wen,
    output logic        wgate,
    output logic [7:0]  wsel,
    output logic [15:0] wdata,
    output logic [15:0] wmask,
    // Read port
    output logic        rclk,
    output logic        rgo,
    output logic        rgate,
    output logic [7:0]  rsel,
    // Preload
    output logic        lvalid,
    output logic [7:0]  laddr,
    output logic [15:0] ldata,
    output logic        done
);
    initial begin
        {wclk, wen, wgate, rclk, rgo, rgate, lvalid, done} = '0; // Writes start off
        {wsel, rsel, laddr, wdata, wmask, ldata} = '0;
    end
    // Pulse lasts one sample so each edge is seen; released controls drop low, other lines invert
    task automatic wr(input logic [7:0] a, input logic [15:0] d, m, input logic e, g);
        @(posedge clk);
        {wclk, wen, wgate, wsel, wdata, wmask} <= {1'b1, e, g, a, d, m}; // One block
        @(posedge clk);
        {wclk, wen, wgate, wsel, wdata, wmask} <= {3'h0, ~a, ~d, ~m};
    endtask
    task automatic rd(input logic [7:0] a, input logic e, g);
        @(posedge clk);
        {rclk, rgo, rgate, rsel} <= {1'b1, e, g, a};
        @(posedge clk);
        {rclk, rgo, rgate, rsel} <= {3'h0, ~a};
    endtask
    task automatic ld(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {lvalid, laddr, ldata} <= {1'b1, a, d};
        @(posedge clk);
        {lvalid, laddr, ldata} <= {1'b0, ~a, ~d};
    endtask
    task automatic fin;
        @(posedge clk);
        done <= 1'b1;
    endtask
    // Enables stay up across the falling sample with new data, so a port
    // that also acted on the falling edge would store the second word
    task automatic wr_fall(input logic [7:0] a, input logic [15:0] d1, d2);
        @(posedge clk);
        {wclk, wen, wgate, wsel, wdata, wmask} <= {3'h7, a, d1, 16'h0000};
        @(posedge clk);
        {wclk, wen, wgate, wsel, wdata, wmask} <= {3'h3, a, d2, 16'h0000};
        @(posedge clk);
        {wclk, wen, wgate, wsel, wdata, wmask} <= {3'h0, ~a, ~d2, 16'hffff};
    endtask
    // Same for reads: the falling sample offers a second address
    task automatic rd_fall(input logic [7:0] a1, a2);
        @(posedge clk);
        {rclk, rgo, rgate, rsel} <= {3'h7, a1};
        @(posedge clk);
        {rclk, rgo, rgate, rsel} <= {3'h3, a2};
        @(posedge clk);
        {rclk, rgo, rgate, rsel} <= {3'h0, ~a2};
    endtask
endmodule

/* File: dv/tb_dpbram_top.sv */
// Self-checking bench for the two-port block memory.
// Assumes the fabric model drives every port input except SYS_CLK and RST from SYS_CLK.
`timescale 1ns/1ps
module tb_dpbram_top;
    logic        clk, rst, ready, refused;
    logic        wclk, wen, wgate, rclk, rgo, rgate, lvalid, done;
    logic [7:0]  wsel, rsel, laddr;
    logic [15:0] wdata, wmask, ldata, rdata;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc        = 0;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    dpbram_fabric fab (.clk, .wclk, .wen, .wgate, .rclk, .rgo, .rgate, .lvalid, .done,
        .wsel, .rsel, .laddr, .wdata, .wmask, .ldata);
    dpbram_top dpbram_top_inst (.SYS_CLK(clk), .RST(rst), .WR_CLK(wclk), .WR_ENABLE(wen),
        .WR_CLOCK_GATE(wgate), .WR_LOCATION_SEL(wsel), .WR_DATA(wdata), .WR_MASK(wmask),
        .RD_CLK(rclk), .RD_GO(rgo), .RD_CLOCK_GATE(rgate), .RD_LOCATION_SEL(rsel),
        .RD_DATA(rdata), .CFG_LOAD_VALID(lvalid), .CFG_LOAD_ADDR(laddr),
        .CFG_LOAD_DATA(ldata), .CFG_DONE(done), .USER_READY(ready),
        .CFG_LOAD_REFUSED(refused));
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Data lands one edge after capture, so look just past that edge
    task automatic rchk(input logic [7:0] a, input logic e, g, input logic [15:0] x);
        fab.rd(a, e, g);
        @(posedge clk);
        #1;
        chk(rdata, x);
    endtask
    task automatic ldchk(input logic [7:0] a, input logic [15:0] d, input logic r);
        fab.ld(a, d);
        #1;
        chk({15'h0, refused}, {15'h0, r});
    endtask
    task automatic t_preload;
        ldchk(8'h00, 16'h1234, 1'b1);
        ldchk(8'h01, 16'ha5c3, 1'b0);
        ldchk(8'hff, 16'h0ff0, 1'b0);
        rchk(8'h01, 1'b1, 1'b1, 16'h0000);
        fab.fin();
        @(posedge clk);
        #1;
        chk({15'h0, ready}, 16'h0001);
        rchk(8'h00, 1'b1, 1'b1, 16'h0000);
        rchk(8'h01, 1'b1, 1'b1, 16'ha5c3);
        rchk(8'hff, 1'b1, 1'b1, 16'h0ff0);
        ldchk(8'h02, 16'h5555, 1'b1);
        rchk(8'h02, 1'b1, 1'b1, 16'h0000);
        $display("test preload done");
    endtask
    task automatic t_write;
        fab.wr(8'h10, 16'hffff, 16'h0000, 1'b1, 1'b1);
        rchk(8'h10, 1'b1, 1'b1, 16'hffff);
        fab.wr(8'h10, 16'h0000, 16'hf00f, 1'b1, 1'b1);
        rchk(8'h10, 1'b1, 1'b1, 16'hf00f);
        fab.wr(8'h10, 16'h0000, 16'h0000, 1'b0, 1'b1);
        fab.wr(8'h10, 16'h0000, 16'h0000, 1'b1, 1'b0);
        rchk(8'h10, 1'b1, 1'b1, 16'hf00f);
        fab.wr(8'h00, 16'h8001, 16'h0000, 1'b1, 1'b1);
        rchk(8'h00, 1'b1, 1'b1, 16'h8001);
        $display("test write done");
    endtask
    task automatic t_rdgate;
        rchk(8'h10, 1'b0, 1'b1, 16'h8001);
        rchk(8'h10, 1'b1, 1'b0, 16'h8001);
        rchk(8'hff, 1'b1, 1'b1, 16'h0ff0);
        $display("test read gate done");
    endtask
    // Default ports act on the rising edge only
    task automatic t_edge;
        fab.wr_fall(8'h20, 16'h1111, 16'heeee);
        rchk(8'h20, 1'b1, 1'b1, 16'h1111);
        fab.rd_fall(8'h01, 8'h20);
        @(posedge clk);
        #1;
        chk(rdata, 16'ha5c3);
        $display("test edge done");
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_preload();
        t_write();
        t_rdgate();
        t_edge();
        end_of_test();
    end
    // About 90 cycles are needed; the ceiling leaves ample margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            $display("wrong value at %0t: timeout", $time);
            end_of_test();
        end
    end
endmodule

/* File: hdl/dpbram_edge.sv */
// Active-edge detector for one memory port clock.
// Assumes the level input is already synchronous to clk.
`timescale 1ns/1ps
module dpbram_edge #(
    parameter bit FALLING = 1'b0
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Port clock
    dpbram_edge_if.det pc
);
    logic level_reg;
    logic level_next;
    logic primed_reg;
    logic primed_next;

    // First sample after reset only primes the history, so a port clock
    // sitting high at release is not mistaken for a rising edge
    always_comb begin
        level_next  = pc.level;
        primed_next = 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_reg  <= 1'b0;
            primed_reg <= 1'b0;
        end else begin
            level_reg  <= level_next;
            primed_reg <= primed_next;
        end
    end

    // Rising by default, falling when selected
    assign pc.active_edge = primed_reg &&
        (FALLING ? (level_reg && !pc.level) : (!level_reg && pc.level));
endmodule

/* File: hdl/dpbram_edge_if.sv */
// Carrier between the top and one port-clock edge detector.
// Assumes the sampled port clock level is synchronous to the system clock.
`timescale 1ns/1ps
interface dpbram_edge_if;
    logic level;
    logic active_edge;

    modport det (
        input  level,
        output active_edge
    );
    modport user (
        output level,
        input  active_edge
    );
endinterface

/* File: hdl/dpbram_pkg.sv */
// Constants for the two-port 256x16 block memory.
// Assumes one system clock; port clocks arrive as plain synchronous inputs.
package dpbram_pkg;
    localparam int          DATA_W       = 16;
    localparam int          ADDR_W       = 8;
    localparam int          DEPTH        = 256;
    localparam bit          WR_FALLING   = 1'b0;
    localparam bit          RD_FALLING   = 1'b0;
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    localparam logic [7:0]  ADDR_RESET   = 8'h00;
    localparam logic [7:0]  NO_PRELOAD   = 8'h00;
    localparam logic [15:0] MASK_KEEPALL = 16'hffff;

    typedef enum logic [0:0] {
        DPBRAM_CONFIG,
        DPBRAM_USER
    } dpbram_phase_t;
endpackage

/* File: hdl/dpbram_top.sv */
// Two-port block memory with masked writes and configuration preload.
// Assumes port clocks, enables and data are synchronous to SYS_CLK,
// and that the configuration loader finishes before user traffic.
`timescale 1ns/1ps
module dpbram_top #(
    parameter int DATA_W     = dpbram_pkg::DATA_W,
    parameter int ADDR_W     = dpbram_pkg::ADDR_W,
    parameter int DEPTH      = dpbram_pkg::DEPTH,
    parameter bit WR_FALLING = dpbram_pkg::WR_FALLING,
    parameter bit RD_FALLING = dpbram_pkg::RD_FALLING
) (
    // System
    input  wire logic              SYS_CLK,
    input  wire logic              RST,
    // Write port
    input  wire logic              WR_CLK,
    input  wire logic              WR_ENABLE,
    input  wire logic              WR_CLOCK_GATE,
    input  wire logic [ADDR_W-1:0] WR_LOCATION_SEL,
    input  wire logic [DATA_W-1:0] WR_DATA,
    input  wire logic [DATA_W-1:0] WR_MASK,
    // Read port
    input  wire logic              RD_CLK,
    input  wire logic              RD_GO,
    input  wire logic              RD_CLOCK_GATE,
    input  wire logic [ADDR_W-1:0] RD_LOCATION_SEL,
    output logic      [DATA_W-1:0] RD_DATA,
    // Configuration preload
    input  wire logic              CFG_LOAD_VALID,
    input  wire logic [ADDR_W-1:0] CFG_LOAD_ADDR,
    input  wire logic [DATA_W-1:0] CFG_LOAD_DATA,
    input  wire logic              CFG_DONE,
    // Status
    output logic                   USER_READY,
    output logic                   CFG_LOAD_REFUSED
);
    // Only the documented shape is served; other sizes are refused
    generate
        if (DATA_W != dpbram_pkg::DATA_W || ADDR_W != dpbram_pkg::ADDR_W ||
            DEPTH != dpbram_pkg::DEPTH) begin : g_bad_shape
            $error("dpbram_top: only 256 words of 16 bits are supported");
        end
    endgenerate

    dpbram_edge_if wr_pc ();
    dpbram_edge_if rd_pc ();

    assign wr_pc.level = WR_CLK;
    assign rd_pc.level = RD_CLK;

    dpbram_edge #(
        .FALLING (WR_FALLING)
    ) u_wr_edge (
        .clk (SYS_CLK),
        .rst (RST),
        .pc  (wr_pc)
    );

    dpbram_edge #(
        .FALLING (RD_FALLING)
    ) u_rd_edge (
        .clk (SYS_CLK),
        .rst (RST),
        .pc  (rd_pc)
    );

    // Phase: preload first, then user traffic
    dpbram_pkg::dpbram_phase_t phase_reg;
    dpbram_pkg::dpbram_phase_t phase_next;
    logic                      ready_reg;
    logic                      ready_next;
    logic                      refused_reg;
    logic                      refused_next;
    logic                      user_ok;

    assign user_ok = (phase_reg == dpbram_pkg::DPBRAM_USER);

    always_comb begin
        phase_next   = phase_reg;
        ready_next   = ready_reg;
        refused_next = 1'b0;
        case (phase_reg)
            dpbram_pkg::DPBRAM_CONFIG: begin
                // Location zero cannot be preloaded; flag the attempt
                if (CFG_LOAD_VALID && CFG_LOAD_ADDR == dpbram_pkg::NO_PRELOAD) begin
                    refused_next = 1'b1;
                end
                if (CFG_DONE) begin
                    phase_next = dpbram_pkg::DPBRAM_USER;
                    ready_next = 1'b1;
                end
            end
            dpbram_pkg::DPBRAM_USER: begin
                // Late loads are refused so a ROM image cannot be disturbed
                refused_next = CFG_LOAD_VALID;
            end
            default: begin
                phase_next = dpbram_pkg::DPBRAM_CONFIG;
                ready_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            phase_reg   <= dpbram_pkg::DPBRAM_CONFIG;
            ready_reg   <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            phase_reg   <= phase_next;
            ready_reg   <= ready_next;
            refused_reg <= refused_next;
        end
    end

    assign USER_READY       = ready_reg;
    assign CFG_LOAD_REFUSED = refused_reg;

    // Write input registers at the array
    logic              wr_pend_reg;
    logic              wr_pend_next;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [ADDR_W-1:0] wr_addr_next;
    logic [DATA_W-1:0] wr_data_reg;
    logic [DATA_W-1:0] wr_data_next;
    logic [DATA_W-1:0] wr_mask_reg;
    logic [DATA_W-1:0] wr_mask_next;
    logic              wr_take;

    // Both enables must be high at the active write edge
    assign wr_take = user_ok && wr_pc.active_edge && WR_ENABLE && WR_CLOCK_GATE;

    always_comb begin
        wr_pend_next = wr_take;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        wr_mask_next = wr_mask_reg;
        if (wr_take) begin
            wr_addr_next = WR_LOCATION_SEL;
            wr_data_next = WR_DATA;
            wr_mask_next = WR_MASK;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= dpbram_pkg::ADDR_RESET;
            wr_data_reg <= dpbram_pkg::WORD_RESET;
            wr_mask_reg <= dpbram_pkg::MASK_KEEPALL;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            wr_mask_reg <= wr_mask_next;
        end
    end

    // Read input registers at the array
    logic              rd_pend_reg;
    logic              rd_pend_next;
    logic [ADDR_W-1:0] rd_addr_reg;
    logic [ADDR_W-1:0] rd_addr_next;
    logic              rd_take;

    assign rd_take = user_ok && rd_pc.active_edge && RD_GO && RD_CLOCK_GATE;

    always_comb begin
        rd_pend_next = rd_take;
        rd_addr_next = rd_addr_reg;
        if (rd_take) begin
            rd_addr_next = RD_LOCATION_SEL;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= dpbram_pkg::ADDR_RESET;
        end else begin
            rd_pend_reg <= rd_pend_next;
            rd_addr_reg <= rd_addr_next;
        end
    end

    // Storage array: flip-flops, one word per index
    logic [DATA_W-1:0] mem_reg  [DEPTH];
    logic [DATA_W-1:0] mem_next [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (!user_ok && CFG_LOAD_VALID && CFG_LOAD_ADDR != dpbram_pkg::NO_PRELOAD) begin
            mem_next[CFG_LOAD_ADDR] = CFG_LOAD_DATA;
        end
        if (wr_pend_reg) begin
            // Masked bits keep their stored value
            mem_next[wr_addr_reg] = (mem_reg[wr_addr_reg] & wr_mask_reg) |
                                    (wr_data_reg & ~wr_mask_reg);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= dpbram_pkg::WORD_RESET;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    // Read data holds unless a qualified read was taken.
    // A read of the word being written in the same cycle returns the old value.
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;

    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_pend_reg) begin
            rd_data_next = mem_reg[rd_addr_reg];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rd_data_reg <= dpbram_pkg::WORD_RESET;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign RD_DATA = rd_data_reg;
endmodule
